// file: host_sys_ctrl_consts.svh
// Register offsets, field positions and reset values for the host system control registers
`ifndef HOST_SYS_CTRL_CONSTS_SVH
`define HOST_SYS_CTRL_CONSTS_SVH
`define BANK_MAC 4'h2
`define BANK_SYS 4'h3
`define OFF_MAC_HIGH 4'h4
`define OFF_BUS_SPEED 4'h0
`define OFF_EEPROM_CTRL 4'h2
`define OFF_SELF_TEST 4'h4
`define OFF_SOFT_RESET 4'h6
`define OFF_BUS_WIDTH 4'h8
`define SPEED_125 2'h0
`define SPEED_25 2'h3
`define CFG_SPEED_BIT 1
`define CFG_WIDTH_BIT 0
`define EE_SW_BIT 4
`define EE_IN_BIT 3
`define EE_DO_BIT 2
`define EE_SK_BIT 1
`define EE_CS_BIT 0
`define SOFT_RESET_BIT 0
`define BUS_WIDTH_BIT 0
`define TX_DONE_BIT 12
`define TX_FAIL_BIT 11
`define RX_DONE_BIT 4
`define RX_FAIL_BIT 3
`define BASE_DEFAULT 16'h0300
`define ZERO16 16'h0000
`endif

// file: host_sys_ctrl_pkg.sv
// Types shared by the host system control register bank
package host_sys_ctrl_pkg;
	typedef enum logic [1:0] {load_idle, load_wait, load_done} load_state_type;
endpackage : host_sys_ctrl_pkg

// file: strap_config_loader.sv
// Captures EEPROM-supplied configuration once after reset release
`timescale 1ns/1ns
`include "host_sys_ctrl_consts.svh"
module strap_config_loader (
	input wire logic clk,
	input wire logic rst,
	input wire logic eeprom_enable_strap,
	input wire logic cfg_valid,
	input wire logic [15:0] cfg_word,
	output logic load_pulse,
	output logic [1:0] loaded_speed,
	output logic loaded_width,
	output logic strap_high
);
	host_sys_ctrl_pkg::load_state_type state;

	// --------------------------------
	// Load sequence
	// --------------------------------
	// Strap is sampled after release, never under reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= host_sys_ctrl_pkg::load_idle;
			load_pulse <= 1'b0;
			loaded_speed <= `SPEED_125;
			loaded_width <= 1'b0;
			strap_high <= 1'b0;
		end else begin
			load_pulse <= 1'b0;
			case (state)
				host_sys_ctrl_pkg::load_idle: begin
					strap_high <= eeprom_enable_strap;
					state <= eeprom_enable_strap ? host_sys_ctrl_pkg::load_wait : host_sys_ctrl_pkg::load_done;
				end
				host_sys_ctrl_pkg::load_wait: begin
					if (cfg_valid) begin
						loaded_speed <= cfg_word[`CFG_SPEED_BIT] ? `SPEED_25 : `SPEED_125; // R4
						loaded_width <= cfg_word[`CFG_WIDTH_BIT]; // R14
						load_pulse <= 1'b1;
						state <= host_sys_ctrl_pkg::load_done;
					end
				end
				default: begin
					state <= host_sys_ctrl_pkg::load_done;
				end
			endcase
		end
	end
endmodule : strap_config_loader

// file: host_system_control_regs.sv
// Host-accessible system control registers: MAC high word, bus speed, EEPROM, self-test, soft reset
//
// Behaviour
// R1: 16-bit read-write register holds the top MAC address word.
// R2: Two-bit speed field selects 125, 62.5, 41.66 or 25 MHz.
// R3: Without EEPROM, speed field resets to 125 MHz code.
// R4: With EEPROM, config bit 1 loads speed 00 or 11.
// R5: Software may overwrite the speed field after EEPROM load.
// R6: Strap high loads base and MAC from EEPROM; low gives base 0x300.
// R7: Software-access bit gates EEPROM pins to the control bits.
// R8: Status bit returns live EEPROM serial input pin level.
// R9: Bits 2..0 drive serial data out, clock and chip select.
// R10: TX self-test done at bit 12, failed at bit 11.
// R11: RX self-test done at bit 4, failed at bit 3.
// R12: Soft reset bit: write 1 activates, 0 releases, resets 0.
// R13: Soft reset hits cores, not base address registers.
// R14: Bus width bit loads from config bit 0 when strap high.
// R15: Bus width bit reads 1 for 16-bit, 0 for 8-bit.
// R16: Reserved bits read zero and ignore writes.
`timescale 1ns/1ns
`include "host_sys_ctrl_consts.svh"
module host_system_control_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] bank_sel,
	input wire logic [3:0] reg_offset,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] write_data,
	output logic [15:0] read_data,
	input wire logic eeprom_enable_strap,
	input wire logic cfg_valid,
	input wire logic [15:0] cfg_word,
	input wire logic [15:0] eeprom_mac_high,
	input wire logic [15:0] eeprom_base_addr,
	input wire logic eeprom_serial_in_pin,
	output logic eeprom_serial_out_pin,
	output logic eeprom_serial_clock_pin,
	output logic eeprom_chip_select_pin,
	output logic eeprom_loader_serial_out,
	input wire logic eeprom_loader_out,
	input wire logic eeprom_loader_clock,
	input wire logic eeprom_loader_select,
	input wire logic tx_mem_test_done,
	input wire logic tx_mem_test_failed,
	input wire logic rx_mem_test_done,
	input wire logic rx_mem_test_failed,
	output logic [1:0] bus_speed_select,
	output logic soft_reset_active,
	output logic [15:0] base_address
);
	logic [15:0] host_mac_address_high;
	logic eeprom_software_access;
	logic [2:0] eeprom_pin_bits;
	logic bus_width_config;
	logic load_pulse;
	logic [1:0] loaded_speed;
	logic loaded_width;
	logic strap_high;
	logic [15:0] next_read_data;

	// Register select helper, shared by write and read decode
	function automatic logic hit(input logic [3:0] bank, input logic [3:0] off,
		input logic [3:0] want_bank, input logic [3:0] want_off);
		hit = (bank == want_bank) && (off == want_off);
	endfunction : hit

	// --------------------------------
	// Configuration load
	// --------------------------------
	strap_config_loader loader (
		.clk(clk),
		.rst(rst),
		.eeprom_enable_strap(eeprom_enable_strap),
		.cfg_valid(cfg_valid),
		.cfg_word(cfg_word),
		.load_pulse(load_pulse),
		.loaded_speed(loaded_speed),
		.loaded_width(loaded_width),
		.strap_high(strap_high)
	);

	// --------------------------------
	// Stored registers
	// --------------------------------
	// MAC high word; EEPROM load wins over a same-cycle write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_mac_address_high <= `ZERO16;
		end else if (load_pulse) begin
			host_mac_address_high <= eeprom_mac_high; // R6
		end else if (reg_write && hit(bank_sel, reg_offset, `BANK_MAC, `OFF_MAC_HIGH)) begin
			host_mac_address_high <= write_data; // R1
		end
	end

	// Base address lives with the bus interface, untouched by soft reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			base_address <= `BASE_DEFAULT; // R6
		end else if (load_pulse) begin
			base_address <= eeprom_base_addr; // R6
		end
	end

	// Speed field: reset to fastest, EEPROM may lower it, software overrides later
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_speed_select <= `SPEED_125; // R3
		end else if (load_pulse) begin
			bus_speed_select <= loaded_speed; // R4
		end else if (reg_write && hit(bank_sel, reg_offset, `BANK_SYS, `OFF_BUS_SPEED)) begin
			bus_speed_select <= write_data[1:0]; // R2 R5 R16
		end
	end

	// EEPROM access and pin bits; bit 3 is read-only and never stored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eeprom_software_access <= 1'b0;
			eeprom_pin_bits <= 3'h0;
		end else if (reg_write && hit(bank_sel, reg_offset, `BANK_SYS, `OFF_EEPROM_CTRL)) begin
			eeprom_software_access <= write_data[`EE_SW_BIT]; // R7
			eeprom_pin_bits <= write_data[`EE_DO_BIT:`EE_CS_BIT]; // R9 R16
		end
	end

	// Soft reset level, held until software writes 0
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			soft_reset_active <= 1'b0; // R12
		end else if (reg_write && hit(bank_sel, reg_offset, `BANK_SYS, `OFF_SOFT_RESET)) begin
			soft_reset_active <= write_data[`SOFT_RESET_BIT]; // R12 R13
		end
	end

	// Bus width is read-only to the host, fed only by the config load
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_width_config <= 1'b0;
		end else if (load_pulse && strap_high) begin
			bus_width_config <= loaded_width; // R14 R15
		end
	end

	// --------------------------------
	// EEPROM pins
	// --------------------------------
	// Software owns the pins only while access is on; otherwise the loader drives them
	always_comb begin
		if (eeprom_software_access) begin
			eeprom_serial_out_pin = eeprom_pin_bits[`EE_DO_BIT]; // R7 R9
			eeprom_serial_clock_pin = eeprom_pin_bits[`EE_SK_BIT]; // R9
			eeprom_chip_select_pin = eeprom_pin_bits[`EE_CS_BIT]; // R9
		end else begin
			eeprom_serial_out_pin = eeprom_loader_out; // R7
			eeprom_serial_clock_pin = eeprom_loader_clock;
			eeprom_chip_select_pin = eeprom_loader_select;
		end
	end

	// Serial input is shared with the loader regardless of access
	assign eeprom_loader_serial_out = eeprom_serial_in_pin;

	// --------------------------------
	// Read path
	// --------------------------------
	// Unmapped offsets and reserved bits read as zero
	always_comb begin
		next_read_data = `ZERO16;
		if (hit(bank_sel, reg_offset, `BANK_MAC, `OFF_MAC_HIGH)) begin
			next_read_data = host_mac_address_high; // R1
		end else if (hit(bank_sel, reg_offset, `BANK_SYS, `OFF_BUS_SPEED)) begin
			next_read_data[1:0] = bus_speed_select; // R16
		end else if (hit(bank_sel, reg_offset, `BANK_SYS, `OFF_EEPROM_CTRL)) begin
			next_read_data[`EE_SW_BIT] = eeprom_software_access;
			next_read_data[`EE_IN_BIT] = eeprom_serial_in_pin; // R8
			next_read_data[`EE_DO_BIT:`EE_CS_BIT] = eeprom_pin_bits;
		end else if (hit(bank_sel, reg_offset, `BANK_SYS, `OFF_SELF_TEST)) begin
			next_read_data[`TX_DONE_BIT] = tx_mem_test_done; // R10
			next_read_data[`TX_FAIL_BIT] = tx_mem_test_failed; // R10
			next_read_data[`RX_DONE_BIT] = rx_mem_test_done; // R11
			next_read_data[`RX_FAIL_BIT] = rx_mem_test_failed; // R11
		end else if (hit(bank_sel, reg_offset, `BANK_SYS, `OFF_SOFT_RESET)) begin
			next_read_data[`SOFT_RESET_BIT] = soft_reset_active;
		end else if (hit(bank_sel, reg_offset, `BANK_SYS, `OFF_BUS_WIDTH)) begin
			next_read_data[`BUS_WIDTH_BIT] = bus_width_config; // R15
		end
	end

	// Read data registered; holds last value between reads
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			read_data <= `ZERO16;
		end else if (reg_read) begin
			read_data <= next_read_data;
		end
	end
endmodule : host_system_control_regs

// file: sys_ctrl_props.sv
// Port-level assertions for the host system control register bank
`timescale 1ns/1ns
module sys_ctrl_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] bank_sel,
	input wire logic [3:0] reg_offset,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] write_data,
	input wire logic [15:0] read_data,
	input wire logic cfg_valid,
	input wire logic eeprom_serial_in_pin,
	input wire logic eeprom_serial_out_pin,
	input wire logic eeprom_chip_select_pin,
	input wire logic eeprom_loader_select,
	input wire logic [1:0] bus_speed_select,
	input wire logic soft_reset_active,
	input wire logic [15:0] base_address
);
	// ----
	// Decodes
	// ----
	logic sys;
	logic wr_ee;
	// Loader wins over a same-cycle write; speed_wr_a excludes cfg_valid cycles, one cycle before the load
	assign sys = bank_sel == 4'h3;
	assign wr_ee = reg_write && sys && reg_offset == 4'h2;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----
	// Properties
	// ----
	pins_sw_a: assert property (wr_ee && write_data[4] |=> eeprom_serial_out_pin == $past(write_data[2]))
		else $error("data pin not from register");
	pins_off_a: assert property (wr_ee && !write_data[4] |=> eeprom_chip_select_pin == eeprom_loader_select)
		else $error("select pin not from loader");
	speed_wr_a: assert property (reg_write && sys && reg_offset == 4'h0 && !cfg_valid |=>
		bus_speed_select == $past(write_data[1:0])) else $error("speed write lost");
	soft_wr_a: assert property (reg_write && sys && reg_offset == 4'h6 |=>
		soft_reset_active == $past(write_data[0])) else $error("soft reset write lost");
	speed_rd_a: assert property (reg_read && sys && reg_offset == 4'h0 |=>
		read_data == {14'h0000, $past(bus_speed_select)}) else $error("speed read wrong");
	ee_in_a: assert property (reg_read && wr_ee == 1'h0 && sys && reg_offset == 4'h2 |=>
		read_data[3] == $past(eeprom_serial_in_pin)) else $error("serial input not live");
	read_hold_a: assert property (!reg_read |=> $stable(read_data)) else $error("read data moved");
	base_keep_a: assert property (soft_reset_active && !cfg_valid |=> $stable(base_address))
		else $error("base address disturbed");
	unmapped_a: assert property (reg_read && bank_sel == 4'h5 |=> read_data == 16'h0000)
		else $error("unmapped read not zero");
endmodule : sys_ctrl_props

bind host_system_control_regs sys_ctrl_props sys_ctrl_props_i (.clk(clk), .rst(rst), .bank_sel(bank_sel),
	.reg_offset(reg_offset), .reg_write(reg_write), .reg_read(reg_read), .write_data(write_data),
	.read_data(read_data), .cfg_valid(cfg_valid), .eeprom_serial_in_pin(eeprom_serial_in_pin),
	.eeprom_serial_out_pin(eeprom_serial_out_pin), .eeprom_chip_select_pin(eeprom_chip_select_pin),
	.eeprom_loader_select(eeprom_loader_select), .bus_speed_select(bus_speed_select),
	.soft_reset_active(soft_reset_active), .base_address(base_address));

// file: serial_eeprom_model.sv
// Behavioural serial EEPROM on the EEPROM pins, driven by software or by the loader
`timescale 1ns/1ns
module serial_eeprom_model (
	input wire logic select,
	input wire logic sclk,
	input wire logic din,
	output logic dout
);
	logic held = 1'h1;
	// Latch on clock rise only while selected
	always @(posedge sclk) begin
		if (select) begin
			held <= din;
		end
	end
	// Pull-up holds the line high when deselected
	assign dout = select ? held : 1'h1;
endmodule : serial_eeprom_model

// file: testbench.sv
// Self-checking bench for the host system control register bank
`timescale 1ns/1ns
module testbench;
	logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, strap = 0, cfg_valid = 0, ld_sel = 0;
	logic tx_d = 0, tx_f = 0, rx_d = 0, rx_f = 0, ee_in, ee_do, ee_sk, ee_cs, srst, ld_so;
	logic [3:0] bank_sel = 4'h0, reg_offset = 4'h0;
	logic [15:0] write_data = 16'h0000, cfg_word = 16'h0000, mac_in = 16'h0000, base_in = 16'h0000;
	logic [15:0] read_data, base;
	logic [1:0] speed;
	int n_mismatch = 0, check_count = 0, cycles = 0;
	always #50 clk = ~clk;
	host_system_control_regs host_system_control_regs_i (.clk(clk), .rst(rst), .bank_sel(bank_sel),
		.reg_offset(reg_offset), .reg_write(reg_write), .reg_read(reg_read), .write_data(write_data),
		.read_data(read_data), .eeprom_enable_strap(strap), .cfg_valid(cfg_valid), .cfg_word(cfg_word),
		.eeprom_mac_high(mac_in), .eeprom_base_addr(base_in), .eeprom_serial_in_pin(ee_in),
		.eeprom_serial_out_pin(ee_do), .eeprom_serial_clock_pin(ee_sk), .eeprom_chip_select_pin(ee_cs),
		.eeprom_loader_serial_out(ld_so), .eeprom_loader_out(1'h0), .eeprom_loader_clock(1'h0),
		.eeprom_loader_select(ld_sel), .tx_mem_test_done(tx_d), .tx_mem_test_failed(tx_f),
		.rx_mem_test_done(rx_d), .rx_mem_test_failed(rx_f), .bus_speed_select(speed),
		.soft_reset_active(srst), .base_address(base));
	serial_eeprom_model serial_eeprom_model_i (.select(ee_cs), .sclk(ee_sk), .din(ee_do), .dout(ee_in));
	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] b, input logic [3:0] o, input logic [15:0] d);
		@(negedge clk);
		bank_sel = b;
		reg_offset = o;
		write_data = d;
		reg_write = 1'h1;
		@(negedge clk);
		reg_write = 1'h0;
	endtask : wr
	// Read data lands one edge after the request
	task automatic rd(input logic [3:0] b, input logic [3:0] o, input logic [15:0] e);
		@(negedge clk);
		bank_sel = b;
		reg_offset = o;
		reg_read = 1'h1;
		@(negedge clk);
		reg_read = 1'h0;
		chk(read_data, e);
	endtask : rd
	// Strap is sampled at the first edge after release, so wait one more
	task automatic do_reset(input logic s);
		@(negedge clk);
		rst = 1'h1;
		strap = s;
		repeat (3) @(negedge clk);
		rst = 1'h0;
		@(negedge clk);
	endtask : do_reset
	task automatic summarize;
		$display("n_mismatch=%0d check_count=%0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	// ----
	// Scenarios
	// ----
	task automatic t_defaults;
		rd(4'h3, 4'h0, 16'h0000);
		rd(4'h3, 4'h6, 16'h0000);
		rd(4'h3, 4'h8, 16'h0000);
		chk(base, 16'h0300);
		wr(4'h2, 4'h4, 16'hA5C3);
		rd(4'h2, 4'h4, 16'hA5C3);
		wr(4'h5, 4'h0, 16'hFFFF);
		rd(4'h5, 4'h0, 16'h0000);
	endtask : t_defaults
	task automatic t_speed;
		for (int i = 0; i < 4; i++) begin
			wr(4'h3, 4'h0, 16'hFFFC | 16'(i));
			rd(4'h3, 4'h0, 16'(i));
			chk({14'h0000, speed}, 16'(i));
		end
	endtask : t_speed
	task automatic t_eeprom;
		wr(4'h3, 4'h2, 16'hFFF4);
		rd(4'h3, 4'h2, 16'h001C);
		wr(4'h3, 4'h2, 16'h0011);
		chk({13'h0000, ee_do, ee_sk, ee_cs}, 16'h0001);
		wr(4'h3, 4'h2, 16'h0013);
		rd(4'h3, 4'h2, 16'h0013);
		chk({15'h0000, ld_so}, {15'h0000, ee_in});
		ld_sel = 1'h1;
		wr(4'h3, 4'h2, 16'h0007);
		chk({13'h0000, ee_do, ee_sk, ee_cs}, 16'h0001);
		rd(4'h3, 4'h2, 16'h0007);
	endtask : t_eeprom
	task automatic t_self_test;
		tx_d = 1'h1;
		rx_d = 1'h1;
		rx_f = 1'h1;
		rd(4'h3, 4'h4, 16'h1018);
		tx_f = 1'h1;
		rx_d = 1'h0;
		rx_f = 1'h0;
		rd(4'h3, 4'h4, 16'h1800);
	endtask : t_self_test
	task automatic t_soft_reset;
		wr(4'h3, 4'h6, 16'hFFFF);
		chk({15'h0000, srst}, 16'h0001);
		rd(4'h3, 4'h6, 16'h0001);
		chk(base, 16'h0300);
		wr(4'h3, 4'h6, 16'h0000);
		chk({15'h0000, srst}, 16'h0000);
	endtask : t_soft_reset
	task automatic t_load;
		do_reset(1'h1);
		cfg_word = 16'h0003;
		mac_in = 16'h1234;
		base_in = 16'h0400;
		cfg_valid = 1'h1;
		@(negedge clk);
		cfg_valid = 1'h0;
		rd(4'h2, 4'h4, 16'h1234);
		rd(4'h3, 4'h0, 16'h0003);
		rd(4'h3, 4'h8, 16'h0001);
		chk(base, 16'h0400);
		wr(4'h3, 4'h0, 16'h0001);
		rd(4'h3, 4'h0, 16'h0001);
	endtask : t_load
	// Hang guard, far above the roughly 75 cycles used
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		do_reset(1'h0);
		t_defaults();
		t_speed();
		t_eeprom();
		t_self_test();
		t_soft_reset();
		t_load();
		summarize();
	end
endmodule : testbench
